// File: hw/sewp_pkg.sv
// Constants and types for the serial EEPROM write-protection block.
package sewp_pkg;
  localparam int unsigned SYNC_W = 6;
  localparam int unsigned IX_SCL = 0;
  localparam int unsigned IX_SDA = 1;
  localparam int unsigned IX_ZERO = 2;
  localparam int unsigned IX_ONE = 3;
  localparam int unsigned IX_TWO = 4;
  localparam int unsigned IX_HV = 5;
  localparam logic [5:0] SYNC_RST = 6'h03;
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  localparam logic [2:0] SEL_SET = 3'h1;
  localparam logic [2:0] SEL_CLR = 3'h3;
  localparam logic [7:0] PROT_TOP = 8'h7f;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_SEVEN = 4'h7;
  localparam logic [3:0] BIT_EIGHT = 4'h8;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [3:0] PAGE_STEP = 4'h1;
  localparam int unsigned MEM_BYTES = 256;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned KHZ_PER_MHZ = 1000;
  localparam int unsigned WR_TIME_MS = 5;
  localparam int unsigned WR_CYCLES = WR_TIME_MS * KHZ_PER_MHZ * CLK_MHZ;
  localparam int unsigned CNT_W = 20;
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  localparam logic [19:0] CNT_ONE = 20'h00001;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MEMW = 3'h1,
    OP_MEMR = 3'h2,
    OP_SETREV = 3'h3,
    OP_CLRREV = 3'h4,
    OP_SETPERM = 3'h5,
    OP_STATUS = 3'h6
  } sewp_op_e;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV = 9'h002,
    ST_DEV_ACK = 9'h004,
    ST_ADDR = 9'h008,
    ST_ADDR_ACK = 9'h010,
    ST_DATA = 9'h020,
    ST_DATA_ACK = 9'h040,
    ST_RD = 9'h080,
    ST_RD_ACK = 9'h100
  } sewp_state_e;
endpackage

// File: hw/sewp_eeprom.sv
// Serial EEPROM slave with reversible and permanent write protection.
`timescale 1ns/1ps
`default_nettype none
module sewp_eeprom #(
  parameter int unsigned WRITE_CYCLES = sewp_pkg::WR_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic strap_input_zero_in,
  input wire logic strap_input_one_in,
  input wire logic strap_input_two_in,
  input wire logic high_voltage_level_in,
  input wire logic nv_reversible_in,
  input wire logic nv_permanent_in,
  output logic reversible_protect_flag_out,
  output logic permanent_protect_out,
  output logic write_busy_out
);
  import sewp_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ****************************************************************
  // Pin synchronisers and glitch filter
  // ****************************************************************
  logic [SYNC_W-1:0] raw, sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  assign raw = {high_voltage_level_in, strap_input_two_in,
    strap_input_one_in, strap_input_zero_in, sda_in, scl_in};
  // A level is taken only once the second and third stages agree.
  always_comb begin
    filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      sync3_q <= SYNC_RST;
      filt_q <= SYNC_RST;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end
  // ****************************************************************
  // Bus events and command decode
  // ****************************************************************
  sewp_state_e st_q, st_d;
  sewp_op_e op_q, op_d, pend_q, pend_d, dec_op;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_q, rd_d, wa_q, wa_d, wd_q, wd_d;
  logic [7:0] byte_in, rd_next;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ack_q, ack_d, oe_q, oe_d, rev_q, rev_d, perm_q, perm_d, busy_q, busy_d;
  logic scl_f, sda_f, hv_f, a1_f, a2_f, scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_c, stop_c, ld_q, we_q, we_d, drv_q;
  logic dec_ack, strap_eq, lower_lock, dev_done, data_done;
  logic [7:0] mem_q [MEM_BYTES];
  assign scl_f = filt_q[IX_SCL];
  assign sda_f = filt_q[IX_SDA];
  assign hv_f = filt_q[IX_HV];
  assign a1_f = filt_q[IX_ONE];
  assign a2_f = filt_q[IX_TWO];
  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;
  assign start_c = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_c = scl_f & scl_prev_q & ~sda_prev_q & sda_f;
  assign byte_in = {sh_q[6:0], sda_f};
  assign rd_next = mem_q[ptr_q];
  assign strap_eq = byte_in[3:1] == {a2_f, a1_f, filt_q[IX_ZERO]};
  assign lower_lock = (ptr_q <= PROT_TOP) && (rev_q || perm_q);
  assign dev_done = (st_q == ST_DEV) && scl_rise && (bit_q == BIT_SEVEN);
  assign data_done = (st_q == ST_DATA) && scl_rise && (bit_q == BIT_SEVEN);
  always_comb begin
    dec_ack = 1'b0;
    dec_op = OP_NONE;
    if (busy_q) begin
      dec_ack = 1'b0;
    end else if (byte_in[7:4] == TYPE_MEM && strap_eq) begin
      dec_ack = 1'b1;
      dec_op = byte_in[0] ? OP_MEMR : OP_MEMW;
    end else if (byte_in[7:4] == TYPE_PROT && !perm_q) begin
      if (hv_f && !a2_f && !a1_f && byte_in[3:1] == SEL_SET) begin
        dec_ack = !rev_q;
        dec_op = byte_in[0] ? OP_STATUS : OP_SETREV;
      end else if (hv_f && !a2_f && a1_f && byte_in[3:1] == SEL_CLR) begin
        dec_ack = 1'b1;
        dec_op = byte_in[0] ? OP_STATUS : OP_CLRREV;
      end else if (!hv_f && strap_eq) begin
        dec_ack = 1'b1;
        dec_op = byte_in[0] ? OP_STATUS : OP_SETPERM;
      end
    end
  end
  // ****************************************************************
  // Protocol engine, protection flags and write timer
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    pend_d = pend_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    ack_d = ack_q;
    oe_d = oe_q;
    rev_d = rev_q;
    perm_d = perm_q;
    we_d = 1'b0;
    wa_d = wa_q;
    wd_d = wd_q;
    cnt_d = (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
    // The flags come back from the non-volatile cells after reset.
    if (!ld_q) begin
      rev_d = nv_reversible_in;
      perm_d = nv_permanent_in;
    end
    if (start_c) begin
      st_d = ST_DEV;
      bit_d = BIT_ZERO;
      oe_d = 1'b0;
      pend_d = OP_NONE;
    end else if (stop_c) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      pend_d = OP_NONE;
      if (pend_q != OP_NONE && !busy_q) begin
        cnt_d = WRITE_CYCLES[CNT_W-1:0];
      end
      case (pend_q)
        OP_SETREV: rev_d = 1'b1;
        OP_CLRREV: rev_d = 1'b0;
        OP_SETPERM: perm_d = 1'b1;
        default: rev_d = rev_d;
      endcase
    end else begin
      case (st_q)
        ST_DEV, ST_ADDR, ST_DATA: begin
          if (scl_rise && bit_q != BIT_EIGHT) begin
            sh_d = byte_in;
            bit_d = bit_q + BIT_ONE;
            if (bit_q == BIT_SEVEN) begin
              if (st_q == ST_DEV) begin
                ack_d = dec_ack;
                op_d = dec_op;
              end else if (st_q == ST_ADDR) begin
                ack_d = 1'b1;
                if (op_q == OP_MEMW) begin
                  ptr_d = byte_in;
                end
              end else if (op_q == OP_MEMW) begin
                ack_d = !lower_lock;
                if (!lower_lock) begin
                  we_d = 1'b1;
                  wa_d = ptr_q;
                  wd_d = byte_in;
                  ptr_d = {ptr_q[7:4], ptr_q[3:0] + PAGE_STEP};
                  pend_d = OP_MEMW;
                end
              end else begin
                ack_d = 1'b1;
                pend_d = op_q;
              end
            end
          end else if (scl_fall && bit_q == BIT_EIGHT) begin
            oe_d = ack_q;
            bit_d = BIT_ZERO;
            if (!ack_q) begin
              st_d = ST_IDLE;
            end else if (st_q == ST_DEV) begin
              st_d = ST_DEV_ACK;
            end else if (st_q == ST_ADDR) begin
              st_d = ST_ADDR_ACK;
            end else begin
              st_d = ST_DATA_ACK;
            end
          end
        end
        ST_DEV_ACK, ST_ADDR_ACK, ST_DATA_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (st_q == ST_DEV_ACK && op_q == OP_MEMR) begin
              rd_d = rd_next;
              ptr_d = ptr_q + PTR_STEP;
              oe_d = !rd_next[7];
              bit_d = BIT_ONE;
              st_d = ST_RD;
            end else if (st_q == ST_DEV_ACK && op_q == OP_STATUS) begin
              st_d = ST_IDLE;
            end else if (st_q == ST_DEV_ACK) begin
              st_d = ST_ADDR;
            end else begin
              st_d = ST_DATA;
            end
          end
        end
        ST_RD: begin
          if (scl_fall && bit_q == BIT_EIGHT) begin
            oe_d = 1'b0;
            st_d = ST_RD_ACK;
          end else if (scl_fall) begin
            rd_d = {rd_q[6:0], 1'b0};
            oe_d = !rd_q[6];
            bit_d = bit_q + BIT_ONE;
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_f) begin
            st_d = ST_IDLE;
          end else if (scl_fall) begin
            rd_d = rd_next;
            ptr_d = ptr_q + PTR_STEP;
            oe_d = !rd_next[7];
            bit_d = BIT_ONE;
            st_d = ST_RD;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
    busy_d = cnt_d != CNT_ZERO;
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= ST_IDLE;
      op_q <= OP_NONE;
      pend_q <= OP_NONE;
      bit_q <= BIT_ZERO;
      sh_q <= '0;
      ptr_q <= '0;
      rd_q <= '0;
      wa_q <= '0;
      wd_q <= '0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      rev_q <= 1'b0;
      perm_q <= 1'b0;
      busy_q <= 1'b0;
      we_q <= 1'b0;
      ld_q <= 1'b0;
      drv_q <= 1'b0;
      cnt_q <= CNT_ZERO;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      pend_q <= pend_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      rev_q <= rev_d;
      perm_q <= perm_d;
      busy_q <= busy_d;
      we_q <= we_d;
      ld_q <= 1'b1;
      drv_q <= 1'b0;
      cnt_q <= cnt_d;
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end
  // The array has no reset so that its contents outlive a reset.
  always_ff @(posedge mclk_in) begin
    if (we_q) begin
      mem_q[wa_q] <= wd_q;
    end
  end
  assign sda_out = drv_q;
  assign sda_oe_out = oe_q;
  assign reversible_protect_flag_out = rev_q;
  assign permanent_protect_out = perm_q;
  assign write_busy_out = busy_q;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_perm_sticky: assert property (ld_q && perm_q |=> perm_q)
    else $error("permanent protection was lost");
  a_prot_locked: assert property (
    dev_done && byte_in[7:4] == TYPE_PROT && perm_q |=> !ack_q)
    else $error("protection command acked after permanent lock");
  a_lower_refused: assert property (
    data_done && op_q == OP_MEMW && lower_lock |=> !ack_q && !we_q)
    else $error("protected lower byte was accepted");
  a_upper_written: assert property (
    data_done && op_q == OP_MEMW && ptr_q > PROT_TOP |=> ack_q && we_q)
    else $error("upper half write was refused");
  a_rev_status: assert property (
    dev_done && !busy_q && !perm_q && hv_f && !a1_f && !a2_f &&
    byte_in == {TYPE_PROT, SEL_SET, 1'b1} |=> ack_q == !$past(rev_q))
    else $error("reversible status answer wrong");
  a_perm_status: assert property (
    dev_done && !busy_q && !perm_q && !hv_f && strap_eq &&
    byte_in[7:4] == TYPE_PROT && byte_in[0] |=> ack_q && op_q == OP_STATUS)
    else $error("permanent status not acked while clear");
  a_busy_nack: assert property (dev_done && busy_q |=> !ack_q)
    else $error("command acked during write cycle");
  a_busy_holds: assert property ($rose(busy_q) |-> busy_q [*4])
    else $error("write cycle ended too soon");
  a_clear_applies: assert property (
    stop_c && pend_q == OP_CLRREV && !busy_q |=> !rev_q && busy_q)
    else $error("clear command did not take effect");
  a_hv_gate: assert property (
    dev_done && !hv_f && !strap_eq && byte_in[7:4] == TYPE_PROT |=> !ack_q)
    else $error("protection command acked without high voltage");
  a_mem_strap: assert property (
    dev_done && byte_in[7:4] == TYPE_MEM && !strap_eq |=> !ack_q)
    else $error("memory access acked with wrong strap bits");
endmodule
`default_nettype wire

// File: sim/sewp_host.sv
// Behavioural bus controller that drives the serial link of the EEPROM.
`timescale 1ns/1ps
`default_nettype none
module sewp_host (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // One quarter of a bus bit, long enough to pass the pin filters.
  task automatic q();
    repeat (8) @(negedge mclk_in);
  endtask
  task automatic start();
    sda_oe_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_oe_out = 1'b1;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_oe_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_oe_out = 1'b0;
    q();
    q();
  endtask
  // Data changes only while the clock is low and is sampled mid-high.
  task automatic bit_x(input logic b, output logic r);
    sda_oe_out = ~b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    k = (r === 1'b0);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, b[i]);
    end
    bit_x(last, r);
  endtask
endmodule
`default_nettype wire

// File: sim/spd_eeprom_write_protect_bench.sv
// Self-checking bench for the serial EEPROM write-protection block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end
module spd_eeprom_write_protect_bench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic s0 = 1'b0, s1 = 1'b0, s2 = 1'b0, hv = 1'b0;
  logic nv_rev = 1'b0, nv_perm = 1'b0;
  wire logic scl, sda, h_oe, d_oe, d_sda, rev, perm, busy;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic k;
  logic [7:0] ks, b;
  // The bus line has a pull-up; either party may pull it low.
  assign sda = ~(h_oe | (d_oe & ~d_sda));
  sewp_eeprom #(.WRITE_CYCLES(400)) i_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(d_sda), .sda_oe_out(d_oe), .strap_input_zero_in(s0),
    .strap_input_one_in(s1), .strap_input_two_in(s2),
    .high_voltage_level_in(hv), .nv_reversible_in(nv_rev),
    .nv_permanent_in(nv_perm), .reversible_protect_flag_out(rev),
    .permanent_protect_out(perm), .write_busy_out(busy));
  sewp_host i_host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(h_oe));
  // Non-volatile cells take the flags during each write cycle.
  always @(negedge mclk_in) begin
    if (busy === 1'b1) begin
      nv_rev <= rev;
      nv_perm <= perm;
    end
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ************************************************************
  // Helpers and scenarios.
  // ************************************************************
  task automatic settle();
    repeat (8) @(negedge mclk_in);
  endtask
  task automatic straps(input logic [3:0] v);
    {hv, s2, s1, s0} = v;
    settle();
  endtask
  task automatic pcycle();
    rst_n_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    settle();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge mclk_in);
    `CHK("busy end", 1'b0, busy)
  endtask
  task automatic wb(input logic [7:0] d);
    i_host.wr_byte(d, k);
    ks = {ks[6:0], k};
  endtask
  // Address and data bytes of protection commands carry no meaning.
  task automatic frame(input logic [7:0] d, input logic [7:0] a);
    ks = 8'h00;
    i_host.start();
    wb(d);
    wb(a);
    wb(8'h5a);
    i_host.stop();
  endtask
  task automatic cmd1(input logic [7:0] d);
    ks = 8'h00;
    i_host.start();
    wb(d);
    i_host.stop();
  endtask
  task automatic t_mem();
    straps(4'h5);
    ks = 8'h00;
    i_host.start();
    wb(8'haa);
    wb(8'h90);
    wb(8'hc3);
    wb(8'h3c);
    wb(8'ha5);
    i_host.stop();
    `CHK("page write", 8'h1f, ks)
    `CHK("write busy", 1'b1, busy)
    wait_idle();
    i_host.start();
    wb(8'haa);
    wb(8'h90);
    i_host.start();
    wb(8'hab);
    i_host.rd_byte(1'b1, b);
    i_host.stop();
    `CHK("random read", 8'hc3, b)
    i_host.start();
    wb(8'hab);
    i_host.rd_byte(1'b0, b);
    `CHK("current read", 8'h3c, b)
    i_host.rd_byte(1'b1, b);
    i_host.stop();
    `CHK("sequential read", 8'ha5, b)
    cmd1(8'ha0);
    `CHK("strap mismatch", 1'b0, ks[0])
  endtask
  task automatic t_rev();
    straps(4'h0);
    frame(8'h62, 8'h00);
    `CHK("set without hv", 3'h0, ks[2:0])
    `CHK("flag without hv", 1'b0, rev)
    straps(4'h8);
    frame(8'h62, 8'h33);
    `CHK("set acks", 3'h7, ks[2:0])
    `CHK("set busy", 1'b1, busy)
    cmd1(8'h62);
    `CHK("ack while busy", 1'b0, ks[0])
    wait_idle();
    `CHK("flag set", 1'b1, rev)
    cmd1(8'h63);
    `CHK("status set", 1'b0, ks[0])
    straps(4'h0);
    frame(8'ha0, 8'h7f);
    `CHK("low write", 3'h6, ks[2:0])
    `CHK("no cycle", 1'b0, busy)
    frame(8'ha0, 8'h80);
    `CHK("high write", 3'h7, ks[2:0])
    wait_idle();
    pcycle();
    `CHK("flag kept", 1'b1, rev)
    straps(4'ha);
    frame(8'h66, 8'hff);
    `CHK("clear acks", 3'h7, ks[2:0])
    wait_idle();
    `CHK("flag clear", 1'b0, rev)
    cmd1(8'h67);
    `CHK("status clear form", 1'b1, ks[0])
    straps(4'h8);
    cmd1(8'h63);
    `CHK("status unset", 1'b1, ks[0])
  endtask
  task automatic t_perm();
    straps(4'h0);
    cmd1(8'h61);
    `CHK("perm status unset", 1'b1, ks[0])
    frame(8'h60, 8'h00);
    `CHK("perm acks", 3'h7, ks[2:0])
    wait_idle();
    `CHK("perm set", 1'b1, perm)
    cmd1(8'h61);
    `CHK("perm status set", 1'b0, ks[0])
    frame(8'ha0, 8'h00);
    `CHK("locked write", 3'h6, ks[2:0])
    straps(4'ha);
    frame(8'h66, 8'h00);
    `CHK("clear refused", 3'h0, ks[2:0])
    straps(4'h8);
    cmd1(8'h63);
    `CHK("status refused", 1'b0, ks[0])
    pcycle();
    `CHK("perm kept", 1'b1, perm)
  endtask
  initial begin
    repeat (4) @(negedge mclk_in);
    rst_n_in = 1'b1;
    settle();
    t_mem();
    t_rev();
    t_perm();
    finish_test();
  end
endmodule
`default_nettype wire
